/* File: psbpm_top.sv */
// Pin-state selector that sets drive, input gating and analog enable of each pad by device state.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - A standby pin-level bit selects defined standby pin states when 1 and held states when 0.
// - A held pin follows its active peripheral, or keeps its latched port output value.
// - A blocked input presents a low level to on-chip logic whatever the pad voltage.
// - A high-impedance pin has its output driver fully off.
// - In standby with the bit at 1 port and peripheral pins float with input forced low, else hold.
// - Trace pins hold except in standby with the bit at 1 where they drive trace, and are unusable in reset; in run the code drives CORE_OUT_IN and CORE_OE_IN.
// - External interrupt and non-maskable interrupt pins hold in run and in both standby settings; in run the code drives CORE_OUT_IN and CORE_OE_IN instead.
// - With unstable supply general pins float and special function selections are unavailable.
// - During external and internal reset general pins float with their input still enabled.
// - The external reset state lasts while its pin is low, and that pin is pulled up with input on.
// - Analog pins float with digital input forced low and analog path on once supply is stable.
// - The main oscillator output drives high when main oscillation stops or outside run and standby, otherwise it holds; in run it drives MAIN_OSC_OUT_IN.
// - The sub oscillator output floats in stop mode and during reset with input forced low.
module psbpm_top (
    // Clock and reset
    input  wire logic                               MCLK_IN,
    input  wire logic                               RESETN_IN,
    // Device state from reset and power controllers
    input  wire logic                               PWR_UNSTABLE_IN,
    input  wire logic                               EXT_RESET_N_PIN_IN,
    input  wire logic                               INT_RESET_IN,
    input  wire logic                               STANDBY_IN,
    input  wire logic                               STOP_MODE_IN,
    input  wire logic                               MAIN_OSC_STOP_IN,
    input  wire logic                               STANDBY_PIN_LEVEL_BIT_IN,
    // Per-pin role and core-side signals
    input  wire logic [3*psbpm_pkg::PSBPM_NPINS-1:0] PIN_ROLE_IN,
    input  wire logic [psbpm_pkg::PSBPM_NPINS-1:0]   CORE_OUT_IN,
    input  wire logic [psbpm_pkg::PSBPM_NPINS-1:0]   CORE_OE_IN,
    input  wire logic [psbpm_pkg::PSBPM_NPINS-1:0]   PERIPH_ACTIVE_IN,
    input  wire logic [psbpm_pkg::PSBPM_NPINS-1:0]   PAD_IN,
    // Pad controls
    output logic      [psbpm_pkg::PSBPM_NPINS-1:0]   PAD_OUT,
    output logic      [psbpm_pkg::PSBPM_NPINS-1:0]   PAD_OE_OUT,
    output logic      [psbpm_pkg::PSBPM_NPINS-1:0]   CORE_IN_OUT,
    output logic      [psbpm_pkg::PSBPM_NPINS-1:0]   ANALOG_EN_OUT,
    // Special pins
    input  wire logic                               MAIN_OSC_OUT_IN,
    input  wire logic                               SUB_OSC_OUT_IN,
    output logic                                    MAIN_OSC_PAD_OUT,
    output logic                                    MAIN_OSC_OE_OUT,
    output logic                                    SUB_OSC_PAD_OUT,
    output logic                                    SUB_OSC_OE_OUT,
    output logic                                    EXT_RESET_PULLUP_OUT,
    output logic                                    EXT_RESET_N_OUT
);
    import psbpm_pkg::*;

    // ------------------------------------------------------------
    // Pad input synchronisers
    // ------------------------------------------------------------
    logic [PSBPM_NPINS-1:0] pad_s1;
    logic [PSBPM_NPINS-1:0] pad_s2;
    logic                   rst_s1;
    logic                   rst_s2;

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pad_s1 <= PSBPM_RST_VEC;
            pad_s2 <= PSBPM_RST_VEC;
        end else begin
            pad_s1 <= PAD_IN;
            pad_s2 <= pad_s1;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rst_s1 <= PSBPM_RST_BIT;
            rst_s2 <= PSBPM_RST_BIT;
        end else begin
            rst_s1 <= EXT_RESET_N_PIN_IN;
            rst_s2 <= rst_s1;
        end
    end

    // ------------------------------------------------------------
    // State priority
    // ------------------------------------------------------------
    psbpm_state_t state;

    always_comb begin
        if (PWR_UNSTABLE_IN)
            state = PSBPM_ST_UNSTABLE;
        else if (!rst_s2)
            state = PSBPM_ST_EXTRST;
        else if (INT_RESET_IN)
            state = PSBPM_ST_INTRST;
        else if (!STANDBY_IN)
            state = PSBPM_ST_RUN;
        else
            state = PSBPM_ST_STANDBY;
    end

    // ------------------------------------------------------------
    // Held port values
    // ------------------------------------------------------------
    logic                   in_standby;
    logic [PSBPM_NPINS-1:0] held_out;
    logic [PSBPM_NPINS-1:0] held_oe;
    logic                   held_main;
    logic                   held_main_oe;
    logic                   held_sub;

    assign in_standby = (state == PSBPM_ST_STANDBY);

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            held_out     <= PSBPM_RST_VEC;
            held_oe      <= PSBPM_RST_VEC;
            held_main    <= PSBPM_RST_BIT;
            held_main_oe <= PSBPM_RST_BIT;
            held_sub     <= PSBPM_RST_BIT;
        end else if (!in_standby) begin
            held_out     <= CORE_OUT_IN;
            held_oe      <= CORE_OE_IN;
            held_main    <= MAIN_OSC_OUT_IN;
            held_main_oe <= (state == PSBPM_ST_RUN);
            held_sub     <= SUB_OSC_OUT_IN;
        end
    end

    // ------------------------------------------------------------
    // Per-pin decode
    // ------------------------------------------------------------
    logic [PSBPM_NPINS-1:0] next_out;
    logic [PSBPM_NPINS-1:0] next_oe;
    logic [PSBPM_NPINS-1:0] next_in;
    logic [PSBPM_NPINS-1:0] next_ana;

    always_comb begin
        logic [2:0] role;
        logic       standby_pin_level_bit;
        logic       hold_o;
        logic       hold_e;
        role   = PSBPM_RST_ROLE;
        standby_pin_level_bit    = STANDBY_PIN_LEVEL_BIT_IN;
        hold_o = 1'b0;
        hold_e = 1'b0;
        for (int i = 0; i < PSBPM_NPINS; i++) begin
            role = PIN_ROLE_IN[3*i +: 3];
            hold_o = PERIPH_ACTIVE_IN[i] ? CORE_OUT_IN[i] : held_out[i];
            hold_e = PERIPH_ACTIVE_IN[i] ? CORE_OE_IN[i] : held_oe[i];
            next_out[i] = 1'b0;
            next_oe[i]  = 1'b0;
            next_in[i]  = 1'b0;
            next_ana[i] = 1'b0;
            if (role == PSBPM_ROLE_ANALOG) begin
                next_ana[i] = (state != PSBPM_ST_UNSTABLE);
            end else begin
                case (state)
                    PSBPM_ST_UNSTABLE: begin
                        next_oe[i] = 1'b0;
                    end
                    PSBPM_ST_EXTRST, PSBPM_ST_INTRST: begin
                        next_in[i] = pad_s2[i];
                    end
                    PSBPM_ST_RUN: begin
                        next_out[i] = CORE_OUT_IN[i];
                        next_oe[i]  = CORE_OE_IN[i];
                        next_in[i]  = pad_s2[i];
                    end
                    PSBPM_ST_STANDBY: begin
                        if (role == PSBPM_ROLE_EXTINT || role == PSBPM_ROLE_NMI || !standby_pin_level_bit) begin
                            next_out[i] = hold_o;
                            next_oe[i]  = hold_e;
                            next_in[i]  = pad_s2[i];
                        end else if (role == PSBPM_ROLE_TRACE) begin
                            next_out[i] = CORE_OUT_IN[i];
                            next_oe[i]  = 1'b1;
                        end else begin
                            next_oe[i] = 1'b0;
                            next_in[i] = 1'b0;
                        end
                    end
                    default: begin
                        next_oe[i] = 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registered pad controls
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            PAD_OUT       <= PSBPM_RST_VEC;
            PAD_OE_OUT    <= PSBPM_RST_VEC;
            CORE_IN_OUT   <= PSBPM_RST_VEC;
            ANALOG_EN_OUT <= PSBPM_RST_VEC;
        end else begin
            PAD_OUT       <= next_out;
            PAD_OE_OUT    <= next_oe;
            CORE_IN_OUT   <= next_in;
            ANALOG_EN_OUT <= next_ana;
        end
    end

    // ------------------------------------------------------------
    // Oscillator and reset pins
    // ------------------------------------------------------------
    logic main_run;

    assign main_run = (state == PSBPM_ST_RUN) || (state == PSBPM_ST_STANDBY);

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            MAIN_OSC_PAD_OUT <= 1'b1;
            MAIN_OSC_OE_OUT  <= 1'b1;
        end else if (!main_run || MAIN_OSC_STOP_IN) begin
            MAIN_OSC_PAD_OUT <= 1'b1;
            MAIN_OSC_OE_OUT  <= 1'b1;
        end else if (in_standby) begin
            MAIN_OSC_PAD_OUT <= held_main;
            MAIN_OSC_OE_OUT  <= held_main_oe;
        end else begin
            MAIN_OSC_PAD_OUT <= MAIN_OSC_OUT_IN;
            MAIN_OSC_OE_OUT  <= 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            SUB_OSC_PAD_OUT <= 1'b0;
            SUB_OSC_OE_OUT  <= 1'b0;
        end else if (!main_run || (in_standby && STOP_MODE_IN)) begin
            SUB_OSC_PAD_OUT <= 1'b0;
            SUB_OSC_OE_OUT  <= 1'b0;
        end else begin
            SUB_OSC_PAD_OUT <= in_standby ? held_sub : SUB_OSC_OUT_IN;
            SUB_OSC_OE_OUT  <= 1'b1;
        end
    end

    assign EXT_RESET_PULLUP_OUT = 1'b1;
    assign EXT_RESET_N_OUT      = rst_s2;

endmodule // psbpm_top
`default_nettype wire

/* File: psbpm_pkg.sv */
// Package with the state type, pin-role, width and reset constants of the pin-state selector.
package psbpm_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          PSBPM_NPINS      = 16;
    localparam logic [15:0] PSBPM_RST_VEC    = 16'h0000;
    localparam logic        PSBPM_RST_BIT    = 1'b0;
    localparam logic [2:0]  PSBPM_RST_ROLE   = 3'h0;

    // ------------------------------------------------------------
    // Pin roles
    // ------------------------------------------------------------
    localparam logic [2:0]  PSBPM_ROLE_GPIO  = 3'h0;
    localparam logic [2:0]  PSBPM_ROLE_PERIPH = 3'h1;
    localparam logic [2:0]  PSBPM_ROLE_TRACE = 3'h2;
    localparam logic [2:0]  PSBPM_ROLE_EXTINT = 3'h3;
    localparam logic [2:0]  PSBPM_ROLE_NMI   = 3'h4;
    localparam logic [2:0]  PSBPM_ROLE_ANALOG = 3'h5;

    typedef enum logic [2:0] {
        PSBPM_ST_UNSTABLE,
        PSBPM_ST_EXTRST,
        PSBPM_ST_INTRST,
        PSBPM_ST_RUN,
        PSBPM_ST_STANDBY
    } psbpm_state_t;

endpackage : psbpm_pkg

/* File: psbpm_board.sv */
// Board-side model of the pads around the pin-state selector.
`timescale 1ns/1ns
`default_nettype none
module psbpm_board import psbpm_pkg::*; (
    input  wire logic                   clk_in,
    input  wire logic [PSBPM_NPINS-1:0] pad_out_in,
    input  wire logic [PSBPM_NPINS-1:0] pad_oe_in,
    input  wire logic [PSBPM_NPINS-1:0] ext_val_in,
    input  wire logic [PSBPM_NPINS-1:0] ext_en_in,
    output logic      [PSBPM_NPINS-1:0] pad_in_out
);
    logic [PSBPM_NPINS-1:0] last;
    // An undriven pad has no pull, so it shows a level that flips every cycle.
    always_ff @(posedge clk_in) begin
        last <= pad_in_out;
    end
    always_comb begin
        for (int i = 0; i < PSBPM_NPINS; i++) begin
            pad_in_out[i] = pad_oe_in[i] ? pad_out_in[i] : ext_en_in[i] ? ext_val_in[i] : ~last[i];
        end
    end
endmodule // psbpm_board
`default_nettype wire

/* File: psbpm_props.sv */
// Checker with the pin-state assertions and its bind.
`timescale 1ns/1ns
`default_nettype none
module psbpm_props import psbpm_pkg::*; (
    input wire logic MCLK_IN, RESETN_IN, PWR_UNSTABLE_IN, EXT_RESET_N_PIN_IN, INT_RESET_IN,
    input wire logic STANDBY_IN, STOP_MODE_IN, MAIN_OSC_STOP_IN, STANDBY_PIN_LEVEL_BIT_IN,
    input wire logic [3*PSBPM_NPINS-1:0] PIN_ROLE_IN,
    input wire logic [PSBPM_NPINS-1:0] CORE_OUT_IN, PAD_OUT, PAD_OE_OUT, CORE_IN_OUT, ANALOG_EN_OUT,
    input wire logic MAIN_OSC_PAD_OUT, MAIN_OSC_OE_OUT, SUB_OSC_OE_OUT,
    input wire logic EXT_RESET_PULLUP_OUT, EXT_RESET_N_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);
    logic [1:0] up;
    logic [PSBPM_NPINS-1:0] tr, fl;
    logic stb1;
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    always_comb begin
        for (int i = 0; i < PSBPM_NPINS; i++) begin
            tr[i] = PIN_ROLE_IN[3*i +: 3] == PSBPM_ROLE_TRACE;
            fl[i] = !(PIN_ROLE_IN[3*i +: 3] inside {PSBPM_ROLE_TRACE, PSBPM_ROLE_EXTINT, PSBPM_ROLE_NMI});
        end
    end
    assign stb1 = STANDBY_IN && STANDBY_PIN_LEVEL_BIT_IN && !PWR_UNSTABLE_IN && !INT_RESET_IN
                  && EXT_RESET_N_OUT;
    chk_unstable_float: assert property (PWR_UNSTABLE_IN |=> PAD_OE_OUT == '0 && ANALOG_EN_OUT == '0)
        else $error("pads active with supply unstable");
    chk_intrst_float: assert property (INT_RESET_IN |=> PAD_OE_OUT == '0)
        else $error("pads driven in internal reset");
    chk_extrst_float: assert property (!EXT_RESET_N_OUT |=> PAD_OE_OUT == '0)
        else $error("pads driven in external reset");
    chk_extrst_sync: assert property (up == 2'h3 |-> EXT_RESET_N_OUT == $past(EXT_RESET_N_PIN_IN, 2))
        else $error("reset pin level wrong");
    chk_pullup_on: assert property (EXT_RESET_PULLUP_OUT)
        else $error("reset pin pull-up off");
    chk_main_osc_high: assert property (MAIN_OSC_STOP_IN |=> MAIN_OSC_PAD_OUT && MAIN_OSC_OE_OUT)
        else $error("main osc pin not high");
    chk_sub_osc_float: assert property (INT_RESET_IN || STANDBY_IN && STOP_MODE_IN |=> !SUB_OSC_OE_OUT)
        else $error("sub osc pin driven");
    chk_analog_blocked: assert property ((ANALOG_EN_OUT & (PAD_OE_OUT | CORE_IN_OUT)) == '0)
        else $error("analog pin not blocked");
    chk_spl_float: assert property (stb1 |=> ((PAD_OE_OUT | CORE_IN_OUT) & $past(fl)) == '0)
        else $error("port pin not floating in standby");
    chk_trace_drive: assert property (stb1 |=> (PAD_OE_OUT & $past(tr)) == $past(tr)
        && ((PAD_OUT ^ $past(CORE_OUT_IN)) & $past(tr)) == '0)
        else $error("trace pin not driving");
    cover property (stb1);
    cover property (!EXT_RESET_N_OUT ##1 EXT_RESET_N_OUT);
    cover property (PWR_UNSTABLE_IN && INT_RESET_IN);
endmodule // psbpm_props
bind psbpm_top psbpm_props chk (.MCLK_IN, .RESETN_IN, .PWR_UNSTABLE_IN, .EXT_RESET_N_PIN_IN,
    .INT_RESET_IN, .STANDBY_IN, .STOP_MODE_IN, .MAIN_OSC_STOP_IN, .STANDBY_PIN_LEVEL_BIT_IN,
    .PIN_ROLE_IN, .CORE_OUT_IN, .PAD_OUT, .PAD_OE_OUT, .CORE_IN_OUT, .ANALOG_EN_OUT,
    .MAIN_OSC_PAD_OUT, .MAIN_OSC_OE_OUT, .SUB_OSC_OE_OUT, .EXT_RESET_PULLUP_OUT, .EXT_RESET_N_OUT);
`default_nettype wire

/* File: psbpm_top_tb.sv */
// Self-checking bench for the pin-state selector.
`timescale 1ns/1ns
`default_nettype none
module psbpm_top_tb;
    import psbpm_pkg::*;
    localparam int N = PSBPM_NPINS;
    logic clk = 1'b0, rstn = 1'b0, unst = 1'b0, extn = 1'b1, irst = 1'b0, stby = 1'b0;
    logic stop = 1'b0, mstop = 1'b0, standby_pin_level_bit = 1'b0, mo = 1'b1, so = 1'b1, b;
    logic [3*N-1:0] role = '0;
    logic [N-1:0] co = '0, coe = '0, pa = '0, ev = '0, een = '1, ko, koe, am, tm, fm;
    logic [N-1:0] pad, po, poe, ci, an, hoe, ho, eoe, eo;
    logic mp, moe, sp, soe, pu, ern;
    int miscompares = 0, n_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    psbpm_top dut (.MCLK_IN(clk), .RESETN_IN(rstn), .PWR_UNSTABLE_IN(unst),
        .EXT_RESET_N_PIN_IN(extn), .INT_RESET_IN(irst), .STANDBY_IN(stby), .STOP_MODE_IN(stop),
        .MAIN_OSC_STOP_IN(mstop), .STANDBY_PIN_LEVEL_BIT_IN(standby_pin_level_bit), .PIN_ROLE_IN(role),
        .CORE_OUT_IN(co), .CORE_OE_IN(coe), .PERIPH_ACTIVE_IN(pa), .PAD_IN(pad), .PAD_OUT(po),
        .PAD_OE_OUT(poe), .CORE_IN_OUT(ci), .ANALOG_EN_OUT(an), .MAIN_OSC_OUT_IN(mo),
        .SUB_OSC_OUT_IN(so), .MAIN_OSC_PAD_OUT(mp), .MAIN_OSC_OE_OUT(moe), .SUB_OSC_PAD_OUT(sp),
        .SUB_OSC_OE_OUT(soe), .EXT_RESET_PULLUP_OUT(pu), .EXT_RESET_N_OUT(ern));
    psbpm_board brd (.clk_in(clk), .pad_out_in(po), .pad_oe_in(poe), .ext_val_in(ev),
        .ext_en_in(een), .pad_in_out(pad));
    function automatic logic [N-1:0] rmask(logic [3*N-1:0] r, logic [2:0] lo, logic [2:0] hi);
        logic [N-1:0] m;
        for (int i = 0; i < N; i++) m[i] = r[3*i +: 3] >= lo && r[3*i +: 3] <= hi;
        return m;
    endfunction
    task automatic chk(string nm, logic [N-1:0] e, logic [N-1:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(67));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        extn <= 1'b0;
        ev <= 16'($urandom);
        step(4);
        chk("oe_extrst", '0, poe);
        chk("in_extrst", ev, ci);
        chk("rst_pin", 16'h0002, N'({pu, ern}));
        @(posedge clk);
        extn <= 1'b1;
        irst <= 1'b1;
        step(4);
        chk("oe_intrst", '0, poe);
        chk("in_intrst", ev, ci);
        chk("sub_rst", '0, N'(soe));
        @(posedge clk);
        {unst, stby, standby_pin_level_bit} <= 3'h7;
        role <= {N{PSBPM_ROLE_TRACE}};
        step(2);
        chk("oe_unst", '0, poe);
        chk("an_unst", '0, an);
        @(posedge clk);
        {unst, irst} <= 2'h0;
        for (int t = 0; t < 32; t++) begin
            for (int i = 0; i < N; i++) role[3*i +: 3] <= 3'(i + t);
            {co, coe, pa, ev, een} <= 80'({$urandom, $urandom, $urandom});
            {stby, stop, mstop, mo, so} <= {3'h0, 2'($urandom)};
            step(2);
            am = rmask(role, PSBPM_ROLE_ANALOG, PSBPM_ROLE_ANALOG);
            chk("oe_run", coe & ~am, poe);
            chk("out_run", co & coe & ~am, po & coe & ~am);
            chk("an_run", am, an);
            chk("osc_run", N'({mo, 1'b1, so, 1'b1}), N'({mp, moe, sp, soe}));
            ko = co;
            koe = coe;
            b = t[0];
            @(posedge clk);
            {stby, standby_pin_level_bit, stop, mstop} <= {1'b1, b, t[1], t[2]};
            {co, coe} <= $urandom;
            step(2);
            tm = rmask(role, PSBPM_ROLE_TRACE, PSBPM_ROLE_TRACE);
            fm = ~(tm | rmask(role, PSBPM_ROLE_EXTINT, PSBPM_ROLE_ANALOG));
            hoe = (pa & coe) | (~pa & koe);
            ho = (pa & co) | (~pa & ko);
            eoe = ~am & (b ? tm | (hoe & ~fm) : hoe);
            eo = b ? (tm & co) | (~tm & ho) : ho;
            chk("oe_stby", eoe, poe);
            chk("out_stby", eo & eoe, po & eoe);
            chk("in_block", '0, ci & (am | (fm & {N{b}})));
            if (t[2]) chk("mosc_stop", 16'h0003, N'({mp, moe}));
            else chk("mosc_hold", N'({mo, 1'b1}), N'({mp, moe}));
            if (t[1]) chk("sosc_stop", '0, N'(soe));
            else chk("sosc_hold", N'({so, 1'b1}), N'({sp, soe}));
            @(posedge clk);
        end
        wrap_up();
    end
endmodule // psbpm_top_tb
`default_nettype wire
